// ===== hdl/kpb_pkg.sv
// package: register map, field layout and reset values of the kernel program base block
// assumes: one 250 MHz clock domain, 32-bit apb register access
package kpb_pkg;
    localparam int unsigned DATA_W           = 32;
    localparam int unsigned ADDR_W           = 12;
    localparam logic [11:0] KPB_BASE_OFFS    = 12'h000;
    localparam logic [11:0] RAM_SIZE_OFFS    = 12'h004;
    localparam logic [11:0] STATUS_OFFS      = 12'h008;
    localparam int unsigned BASE_FIELD_LSB   = 10;
    localparam int unsigned BASE_FIELD_MSB   = 15;
    localparam int unsigned BASE_FIELD_W     = 6;
    localparam logic [5:0]  BASE_FIELD_RST   = 6'h00;
    localparam logic [5:0]  RAM_SIZE_RST     = 6'h3F;
    localparam logic [31:0] BASE_WRITE_MASK  = 32'h0000_FC00;
    localparam int unsigned STATUS_ABOVE_BIT = 0;
    localparam int unsigned STATUS_PART_BIT  = 1;
    localparam int unsigned STATUS_ERR_BIT   = 2;
endpackage : kpb_pkg

// ===== hdl/kpb_field_if.sv
// interface: carries a six-bit partition field and its write strobe between modules
// assumes: one clock domain
`timescale 1ns/1ps
`default_nettype none
interface kpb_field_if #(parameter int unsigned W = 6);
    logic         wr_en;
    logic [W-1:0] wr_val;
    logic [W-1:0] value;
    modport owner (input wr_en, input wr_val, output value);
    modport user  (output wr_en, output wr_val, input value);
endinterface : kpb_field_if
`default_nettype wire

// ===== hdl/kpb_field_reg.sv
// module: one writable partition field held in flip-flops
// assumes: write strobe is a single-cycle pulse from the bus decoder
`timescale 1ns/1ps
`default_nettype none
module kpb_field_reg #(
    parameter int unsigned W   = 6,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic  i_clk,
    input  wire logic  i_rst,
    kpb_field_if.owner fld
);
    logic [W-1:0] val_q;
    logic [W-1:0] val_d;

    // an empty field holds nothing, and one wider than the bus word cannot be written
    if (W < 1 || W > 32) begin : g_w_chk
        $error("field width out of range");
    end

    assign val_d     = fld.wr_en ? fld.wr_val : val_q;
    assign fld.value = val_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            val_q <= RST;
        end else begin
            val_q <= val_d;
        end
    end
endmodule : kpb_field_reg
`default_nettype wire

// ===== hdl/kpb_base_reg.sv
// top: kernel program base register with apb slave and partition outputs
// assumes: apb master in the I_REF_CLK domain, zero-wait answers
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module kpb_base_reg (
    input  wire logic                      I_REF_CLK,
    input  wire logic                      I_RST,
    input  wire logic                      I_PSEL,
    input  wire logic                      I_PENABLE,
    input  wire logic                      I_PWRITE,
    input  wire logic [kpb_pkg::ADDR_W-1:0] I_PADDR,
    input  wire logic [kpb_pkg::DATA_W-1:0] I_PWDATA,
    input  wire logic [3:0]                I_PSTRB,
    output logic      [kpb_pkg::DATA_W-1:0] O_PRDATA,
    output logic                           O_PREADY,
    output logic                           O_PSLVERR,
    output logic      [kpb_pkg::DATA_W-1:0] O_KERNEL_PROG_BASE,
    output logic                           O_KERNEL_PROG_PART,
    output logic                           O_BASE_ABOVE_SIZE
);
    import kpb_pkg::*;

    // the read words are built from fixed slices, so refuse a package layout they cannot serve
    if (BASE_FIELD_MSB - BASE_FIELD_LSB + 1 != BASE_FIELD_W) begin : g_field_w_chk
        $error("base field bounds disagree with its width");
    end
    if (BASE_FIELD_LSB != 10 || BASE_FIELD_MSB != 15) begin : g_field_pos_chk
        $error("base field must sit in bits 15 to 10");
    end
    if (BASE_WRITE_MASK != {16'h0000, {BASE_FIELD_W{1'h1}}, 10'h000}) begin : g_mask_chk
        $error("write mask does not cover the base field");
    end
    if (DATA_W != 32) begin : g_data_w_chk
        $error("register word must be 32 bits wide");
    end
    if (ADDR_W < 4) begin : g_addr_w_chk
        $error("address too narrow for three word registers");
    end
    if (RAM_SIZE_OFFS == KPB_BASE_OFFS || STATUS_OFFS == KPB_BASE_OFFS
            || STATUS_OFFS == RAM_SIZE_OFFS) begin : g_map_chk
        $error("register offsets overlap");
    end

    kpb_field_if #(.W(BASE_FIELD_W)) base_if ();
    kpb_field_if #(.W(BASE_FIELD_W)) size_if ();

    logic                 access;
    logic                 wr_access;
    logic                 rd_access;
    logic                 sel_base;
    logic                 sel_size;
    logic                 sel_stat;
    logic                 mapped;
    logic                 strobe_hi;
    logic [DATA_W-1:0]    base_word;
    logic [DATA_W-1:0]    size_word;
    logic [DATA_W-1:0]    stat_word;
    logic [DATA_W-1:0]    rd_mux;
    logic                 above;
    logic                 part_flag;
    logic                 err_set;
    logic                 err_clr;
    logic                 err_q;
    logic                 err_d;
    logic [DATA_W-1:0]    prdata_q;
    logic [DATA_W-1:0]    prdata_d;

    assign access    = I_PSEL & I_PENABLE;
    assign wr_access = access & I_PWRITE;
    assign rd_access = access & ~I_PWRITE;
    assign sel_base  = (I_PADDR == KPB_BASE_OFFS);
    assign sel_size  = (I_PADDR == RAM_SIZE_OFFS);
    assign sel_stat  = (I_PADDR == STATUS_OFFS);
    assign mapped    = sel_base | sel_size | sel_stat;
    // the field lies wholly in byte lane 1, so only that strobe matters
    assign strobe_hi = I_PSTRB[1];

    // only bits 15:10 of the write word reach storage
    assign base_if.wr_en  = wr_access & sel_base & strobe_hi;
    assign base_if.wr_val = I_PWDATA[BASE_FIELD_MSB:BASE_FIELD_LSB];
    assign size_if.wr_en  = wr_access & sel_size & strobe_hi;
    assign size_if.wr_val = I_PWDATA[BASE_FIELD_MSB:BASE_FIELD_LSB];

    kpb_field_reg #(.W(BASE_FIELD_W), .RST(BASE_FIELD_RST)) u_base (
        .i_clk (I_REF_CLK),
        .i_rst (I_RST),
        .fld   (base_if)
    );

    // stands in for the companion size register; base is checked against it
    kpb_field_reg #(.W(BASE_FIELD_W), .RST(RAM_SIZE_RST)) u_size (
        .i_clk (I_REF_CLK),
        .i_rst (I_RST),
        .fld   (size_if)
    );

    // upper half and low ten bits are constant zero, never stored
    assign base_word = {16'h0000, base_if.value, 10'h000};
    assign size_word = {16'h0000, size_if.value, 10'h000};
    // software is trusted to keep base <= size; we only flag a violation
    assign above     = base_if.value > size_if.value;
    assign part_flag = (base_if.value != 6'h00);
    assign stat_word = {29'h0, err_q, part_flag, above};
    assign rd_mux    = sel_base ? base_word :
                       sel_size ? size_word :
                       sel_stat ? stat_word : 32'h0000_0000;

    assign prdata_d = rd_access ? rd_mux : prdata_q;
    // sticky error on any unmapped access; set beats a status read clear
    assign err_set  = access & ~mapped;
    assign err_clr  = rd_access & sel_stat;
    assign err_d    = err_set | (err_q & ~err_clr);

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            prdata_q <= 32'h0000_0000;
            err_q    <= 1'h0;
        end else begin
            prdata_q <= prdata_d;
            err_q    <= err_d;
        end
    end

    // zero wait states: rdata is combinational in the access phase
    assign O_PREADY           = 1'h1;
    assign O_PSLVERR          = err_set;
    assign O_PRDATA           = rd_access ? rd_mux : prdata_q;
    assign O_KERNEL_PROG_BASE = base_word;
    assign O_KERNEL_PROG_PART = part_flag;
    assign O_BASE_ABOVE_SIZE  = above;

    // base register contents, read word and reset values
    upper_zero_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        O_KERNEL_PROG_BASE[31:16] == 16'h0000
    ) else $error("base upper half not zero");

    read_upper_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        rd_access && sel_base
        |-> O_PRDATA[31:16] == 16'h0000
    ) else $error("base read upper half not zero");

    low_zero_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        rd_access && sel_base
        |-> O_PRDATA[9:0] == 10'h000
    ) else $error("base low bits not zero");

    write_lands_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        wr_access && sel_base && strobe_hi
        |=> O_KERNEL_PROG_BASE == ($past(I_PWDATA) & BASE_WRITE_MASK)
    ) else $error("base write did not land");

    fixed_bits_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        wr_access && sel_base
        |=> (O_KERNEL_PROG_BASE & ~BASE_WRITE_MASK) == 32'h0000_0000
    ) else $error("write reached a fixed base bit");

    hold_value_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        !(wr_access && sel_base)
        |=> $stable(O_KERNEL_PROG_BASE)
    ) else $error("base changed without write");

    strobe_gate_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        wr_access && sel_base && !strobe_hi
        |=> $stable(O_KERNEL_PROG_BASE)
    ) else $error("base changed with lane strobe off");

    base_readback_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        rd_access && sel_base
        |-> O_PRDATA == O_KERNEL_PROG_BASE
    ) else $error("base read differs from stored base");

    reset_zero_a: assert property (
        @(posedge I_REF_CLK)
        $fell(I_RST)
        |-> O_KERNEL_PROG_BASE == 32'h0000_0000 && !O_KERNEL_PROG_PART
    ) else $error("base not zero after reset");

    size_reset_a: assert property (
        @(posedge I_REF_CLK)
        $fell(I_RST)
        |-> size_if.value == RAM_SIZE_RST && !err_q && O_PRDATA == 32'h0000_0000
    ) else $error("size or status not at reset value");

    // size limit register, status flags, sticky error and read data hold
    size_write_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        wr_access && sel_size && strobe_hi
        |=> size_word == ($past(I_PWDATA) & BASE_WRITE_MASK)
    ) else $error("size write did not land");

    size_hold_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        !(wr_access && sel_size && strobe_hi)
        |=> $stable(size_if.value)
    ) else $error("size changed without write");

    size_read_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        rd_access && sel_size
        |-> O_PRDATA == size_word
    ) else $error("size read wrong");

    size_flag_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        O_BASE_ABOVE_SIZE == (O_KERNEL_PROG_BASE[15:10] > size_if.value)
    ) else $error("size flag wrong");

    part_flag_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        O_KERNEL_PROG_PART == (O_KERNEL_PROG_BASE != 32'h0000_0000)
    ) else $error("partition flag wrong");

    stat_read_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        rd_access && sel_stat
        |-> O_PRDATA[STATUS_ABOVE_BIT] == O_BASE_ABOVE_SIZE
            && O_PRDATA[STATUS_PART_BIT] == O_KERNEL_PROG_PART
            && O_PRDATA[STATUS_ERR_BIT] == err_q
            && O_PRDATA[31:3] == 29'h0
    ) else $error("status read wrong");

    unmapped_err_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        access && !mapped
        |-> O_PSLVERR ##1 err_q
    ) else $error("unmapped access not flagged");

    unmapped_read_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        rd_access && !mapped
        |-> O_PRDATA == 32'h0000_0000
    ) else $error("unmapped read not zero");

    slverr_idle_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        !access
        |-> !O_PSLVERR
    ) else $error("slave error outside access");

    err_clear_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        rd_access && sel_stat
        |=> !err_q
    ) else $error("status read did not clear error");

    err_hold_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        err_q && !(rd_access && sel_stat)
        |=> err_q
    ) else $error("sticky error lost");

    rdata_stands_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        rd_access ##1 !rd_access
        |-> O_PRDATA == $past(O_PRDATA)
    ) else $error("read data not held");

    write_no_read_a: assert property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        wr_access
        |=> $stable(O_PRDATA)
    ) else $error("write disturbed read data");

    // main scenarios
    base_write_c: cover property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        wr_access && sel_base && I_PWDATA[15:10] != 6'h00
    );

    base_read_c: cover property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        rd_access && sel_base && O_KERNEL_PROG_PART
    );

    above_c: cover property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        $rose(O_BASE_ABOVE_SIZE)
    );

    unmapped_c: cover property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        access && !mapped
    );

    err_clear_c: cover property (
        @(posedge I_REF_CLK) disable iff (I_RST)
        rd_access && sel_stat && err_q
    );
endmodule : kpb_base_reg
`default_nettype wire

// ===== tb/kernel_program_ram_base_reg_test.sv
// testbench: apb register checks of the kernel program base block
// assumes: design answers through pready on one 250 MHz clock, async active-high reset
`timescale 1ns/1ps
`default_nettype none
module kernel_program_ram_base_reg_test;
    import kpb_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, part, above, er;
    logic [11:0] paddr;
    logic [3:0]  pstrb;
    logic [31:0] pwdata, prdata, base, rd;
    int          err_count, samples_checked;
    // write data beside the base it should leave; fixed bits must drop out
    logic [31:0] rows [5][2] = '{'{32'hFFFF_FFFF, 32'h0000_FC00}, '{32'h0000_0400, 32'h0000_0400},
        '{32'hFFFF_03FF, 32'h0000_0000}, '{32'h0001_0800, 32'h0000_0800},
        '{32'h0000_8000, 32'h0000_8000}};
    kpb_base_reg dut (.I_REF_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .O_KERNEL_PROG_BASE(base), .O_KERNEL_PROG_PART(part), .O_BASE_ABOVE_SIZE(above));
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    task end_sim;
        $display("counts: %0d mismatches in %0d checks", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // holds the request until pready is seen high; the bench watchdog ends a hang
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        #1;
    endtask : apb
    initial begin
        #5000;
        err_count++;
        $display("watchdog expired");
        end_sim();
    end
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        rst = 1'h1;
        repeat (8) @(posedge clk);
        chk("base in reset", 32'h0, base);
        rst <= 1'h0;
        apb(1'h0, KPB_BASE_OFFS, 32'h0, 4'hF);
        chk("read after reset", 32'h0, rd);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            apb(1'h1, KPB_BASE_OFFS, rows[i][0], 4'hF);
            chk("base out", rows[i][1], base);
            apb(1'h0, KPB_BASE_OFFS, 32'h0, 4'hF);
            chk("base read", rows[i][1], rd);
            chk("mapped no error", 32'h0, {31'h0, er});
            chk("partition", {31'h0, rows[i][1] != 32'h0}, {31'h0, part});
        end
        $display("test rows done");
        apb(1'h1, 12'hFFC, 32'hFFFF_FFFF, 4'hF);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("base after unmapped", 32'h0000_8000, base);
        apb(1'h1, KPB_BASE_OFFS, 32'h0, 4'hD);
        chk("base strobe off", 32'h0000_8000, base);
        // size below the base on purpose: software broke the limit, the flag must say so
        apb(1'h1, RAM_SIZE_OFFS, 32'h0000_0400, 4'hF);
        chk("above size", 32'h1, {31'h0, above});
        apb(1'h0, RAM_SIZE_OFFS, 32'h0, 4'hF);
        chk("size read", 32'h0000_0400, rd);
        apb(1'h0, STATUS_OFFS, 32'h0, 4'hF);
        chk("status sticky", 32'h0000_0007, rd);
        apb(1'h0, STATUS_OFFS, 32'h0, 4'hF);
        chk("status cleared", 32'h0000_0003, rd);
        apb(1'h0, 12'hFFC, 32'h0, 4'hF);
        chk("unmapped read", 32'h0, rd);
        chk("unmapped read error", 32'h1, {31'h0, er});
        $display("test awkward done");
        @(posedge clk);
        rst <= 1'h1;
        @(negedge clk);
        chk("base mid reset", 32'h0, base);
        @(posedge clk);
        rst <= 1'h0;
        apb(1'h0, KPB_BASE_OFFS, 32'h0, 4'hF);
        chk("read after second reset", 32'h0, rd);
        chk("above after reset", 32'h0, {31'h0, above});
        apb(1'h0, STATUS_OFFS, 32'h0, 4'hF);
        chk("status after second reset", 32'h0, rd);
        apb(1'h0, RAM_SIZE_OFFS, 32'h0, 4'hF);
        chk("size after second reset", {16'h0000, RAM_SIZE_RST, 10'h000}, rd);
        $display("test second reset done");
        end_sim();
    end
endmodule : kernel_program_ram_base_reg_test
`default_nettype wire
